// >>> rtl/ufo_top.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ufo_regs.svh"
module ufo_top
    import ufo_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] sof_rx,
    input wire logic [1:0] eop_rx,
    input wire logic [1:0][10:0] sof_frame,
    input wire logic [1:0] full_speed,
    input wire logic vbus_ttl,
    input wire logic otg_id,
    input wire logic vbus_valid,
    output logic vbus_pullup_en,
    output logic rx_pwrdn,
    output logic chg_pump_en,
    output logic vbus_dischg_en,
    output logic dp_pu_en,
    output logic dm_pu_en,
    output logic dp_pd_en,
    output logic dm_pd_en
);

    // ************************************************************
    // elaboration check
    // ************************************************************

    // the index decode needs address bits 17:2
    generate
        if (ADDR_W < 18) begin : g_chk
            $error("ufo_top: ADDR_W must be at least 18");
        end
    endgenerate

    // ************************************************************
    // declarations
    // ************************************************************

    localparam logic [1:0][15:0] IDX_CNT = {`UFO_IDX_COUNT2, `UFO_IDX_COUNT1};
    localparam logic [1:0][15:0] IDX_IEN = {`UFO_IDX_IEN2, `UFO_IDX_IEN1};
    localparam logic [1:0][15:0] IDX_STAT = {`UFO_IDX_STAT2, `UFO_IDX_STAT1};

    ufo_state_t q;
    ufo_state_t n;
    logic [15:0] idx;
    logic setup;
    logic wr;
    logic [15:0] rv;
    logic hit;
    logic [5:0] sum;

    // ************************************************************
    // bus decode
    // ************************************************************

    // setup phase, and the access edge at which a write lands
    assign idx = paddr[17:2];
    assign setup = psel & ~penable;
    assign wr = psel & penable & q.pready & pwrite;
    // time-base accumulator step
    assign sum = {1'b0, q.acc} + `UFO_TB_MHZ;

    // read multiplexer
    always_comb begin
        rv = 16'h0000;
        hit = 1'b1;
        case (idx)
            `UFO_IDX_FRAME1: rv = {q.tof[0], q.occ[0], 1'b0, q.frame[0]};
            `UFO_IDX_FRAME2: rv = {q.tof[1], q.occ[1], 1'b0, q.frame[1]};
            `UFO_IDX_COUNT1: rv = {2'b00, q.cnt[0]};
            `UFO_IDX_COUNT2: rv = {2'b00, q.cnt[1]};
            `UFO_IDX_OTG: rv = {2'b00, q.otg, 3'b000, q.pin};
            `UFO_IDX_IEN1: rv = {15'h0000, q.ien[0]};
            `UFO_IDX_IEN2: rv = {15'h0000, q.ien[1]};
            `UFO_IDX_STAT1: rv = {14'h0000, q.sofr[0], q.tof[0]};
            `UFO_IDX_STAT2: rv = {14'h0000, q.sofr[1], q.tof[1]};
            default: hit = 1'b0;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************

    always_comb begin
        n = q;
        // no wait state: ready in the first access cycle
        n.pready = setup;
        if (setup) begin
            n.prdata = {16'h0000, rv};
            n.pslverr = ~hit;
        end
        // pin synchronisers; a level counts once stages two and three agree
        n.sync = {q.sync[1:0], {vbus_ttl, otg_id, vbus_valid}};
        for (int p = 0; p < 3; p++) begin
            if (q.sync[1][p] == q.sync[2][p]) begin
                n.pin[p] = q.sync[2][p];
            end
        end
        // 12 MHz tick from the 20 MHz clock by fractional accumulation
        if (sum >= `UFO_CLK_MHZ) begin
            n.tick = 1'b1;
            n.acc = 5'(sum - `UFO_CLK_MHZ);
        end else begin
            n.tick = 1'b0;
            n.acc = sum[4:0];
        end
        // otg_port_control_status bits
        if (wr && idx == `UFO_IDX_OTG) begin
            n.otg = pwdata[`UFO_OTG_HI:`UFO_OTG_LO];
        end
        // per device: register writes, then events, so a set beats a clear
        for (int d = 0; d < 2; d++) begin
            if (wr && idx == IDX_CNT[d]) begin
                n.reload[d] = pwdata[`UFO_CNT_HI:0];
                n.cnt[d] = pwdata[`UFO_CNT_HI:0];
            end
            if (wr && idx == IDX_IEN[d]) begin
                n.ien[d] = pwdata[`UFO_IEN_TOF];
            end
            if (wr && idx == IDX_STAT[d]) begin
                n.tof[d] = q.tof[d] & ~pwdata[`UFO_STAT_TOF];
                n.sofr[d] = q.sofr[d] & ~pwdata[`UFO_STAT_SOF];
            end
            if (sof_rx[d] | eop_rx[d]) begin
                n.cnt[d] = n.reload[d];
                n.sofr[d] = 1'b1;
                if (q.ien[d]) begin
                    n.occ[d] = 3'h0;
                end
                if (sof_rx[d] & full_speed[d]) begin
                    n.frame[d] = sof_frame[d];
                end
            end else if (q.tick && !(wr && idx == IDX_CNT[d])) begin
                if (q.cnt[d] == 14'h0000) begin
                    n.cnt[d] = n.reload[d];
                    if (q.ien[d]) begin
                        n.tof[d] = 1'b1;
                        if (q.occ[d] != 3'h7) begin
                            n.occ[d] = q.occ[d] + 3'h1;
                        end
                    end
                end else begin
                    n.cnt[d] = q.cnt[d] - 14'h0001;
                end
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.reload <= {`UFO_CNT_RST, `UFO_CNT_RST};
            q.cnt <= {`UFO_CNT_RST, `UFO_CNT_RST};
        end else begin
            q <= n;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // bus answer
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    // otg analogue controls, taken only from the otg register
    assign vbus_pullup_en = q.otg[7];
    assign rx_pwrdn = q.otg[6];
    assign chg_pump_en = q.otg[5];
    assign vbus_dischg_en = q.otg[4];
    assign dp_pu_en = q.otg[3];
    assign dm_pu_en = q.otg[2];
    assign dp_pd_en = q.otg[1];
    assign dm_pd_en = q.otg[0];

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper terms for device one
    logic ev0;
    logic wc0;
    logic exp0;
    assign ev0 = sof_rx[0] | eop_rx[0];
    assign wc0 = wr && idx == IDX_CNT[0];
    assign exp0 = q.tick && q.cnt[0] == 14'h0000 && !ev0 && !wc0;

    a_tof_on_expiry: assert property (
        exp0 && q.ien[0] |=> q.tof[0]
    ) else $error("timeout flag not set on expiry");

    a_tof_no_cause: assert property (
        !q.tof[0] && !(exp0 && q.ien[0]) |=> !q.tof[0]
    ) else $error("timeout flag set without an enabled expiry");

    a_occ_counts: assert property (
        exp0 && q.ien[0] && q.occ[0] != 3'h7 |=> q.occ[0] == $past(q.occ[0]) + 3'h1
    ) else $error("occurrence counter did not step");

    a_occ_saturate: assert property (
        exp0 && q.ien[0] && q.occ[0] == 3'h7 |=> q.occ[0] == 3'h7
    ) else $error("occurrence counter wrapped");

    a_occ_cleared: assert property (
        ev0 && q.ien[0] |=> q.occ[0] == 3'h0
    ) else $error("occurrence counter not cleared by sof");

    a_occ_frozen: assert property (
        !q.ien[0] |=> $stable(q.occ[0])
    ) else $error("occurrence counter moved while disabled");

    a_frame_capture: assert property (
        sof_rx[0] && full_speed[0] |=> q.frame[0] == $past(sof_frame[0])
    ) else $error("frame number not captured");

    a_frame_kept: assert property (
        !(sof_rx[0] && full_speed[0]) |=> $stable(q.frame[0])
    ) else $error("frame number changed without sof");

    a_no_tick_hold: assert property (
        !q.tick && !ev0 && !wc0 |=> $stable(q.cnt[0])
    ) else $error("counter moved without a tick");

    a_cnt_steps: assert property (
        q.tick && q.cnt[0] != 14'h0000 && !ev0 && !wc0
        |=> q.cnt[0] == $past(q.cnt[0]) - 14'h0001
    ) else $error("counter did not decrement");

    a_cnt_reload: assert property (
        ev0 && !wc0 |=> q.cnt[0] == q.reload[0]
    ) else $error("counter not reloaded on sof");

    a_tick_gap: assert property (
        q.tick [*3] |-> 1'b0
    ) else $error("time base ticks too fast");

    a_set_wins: assert property (
        exp0 && q.ien[0] && wr && idx == IDX_STAT[0] |=> q.tof[0]
    ) else $error("flag set lost to a clear");

    a_w1c_clear: assert property (
        wr && idx == IDX_STAT[0] && pwdata[0] && !exp0 |=> !q.tof[0]
    ) else $error("flag not cleared by write one");

    a_otg_pullup: assert property (
        wr && idx == `UFO_IDX_OTG |=> dp_pu_en == $past(pwdata[9])
            && vbus_pullup_en == $past(pwdata[13])
    ) else $error("otg_port_control_status outputs do not follow write");

    a_cnt_readback: assert property (
        setup && idx == IDX_CNT[0] |=> prdata[13:0] == $past(q.cnt[0]) && pready
    ) else $error("count readback wrong");

    // helper terms for device two
    logic ev1;
    logic wc1;
    logic exp1;
    assign ev1 = sof_rx[1] | eop_rx[1];
    assign wc1 = wr && idx == IDX_CNT[1];
    assign exp1 = q.tick && q.cnt[1] == 14'h0000 && !ev1 && !wc1;

    a_tof_set_two: assert property (
        exp1 && q.ien[1] |=> q.tof[1]
    ) else $error("device two timeout flag not set");

    a_occ_clear_two: assert property (
        ev1 && q.ien[1] |=> q.occ[1] == 3'h0
    ) else $error("device two occurrence counter not cleared");

    a_cnt_step_two: assert property (
        q.tick && q.cnt[1] != 14'h0000 && !ev1 && !wc1
        |=> q.cnt[1] == $past(q.cnt[1]) - 14'h0001
    ) else $error("device two counter did not decrement");

    a_reload_two: assert property (
        ev1 && !wc1 |=> q.cnt[1] == q.reload[1]
    ) else $error("device two counter not reloaded");

    a_low_speed_hold: assert property (
        sof_rx[1] && !full_speed[1] |=> $stable(q.frame[1])
    ) else $error("frame captured at low speed");

    // a pin level is taken once the last two stages agree
    a_ttl_sync: assert property (
        q.sync[1][2] == q.sync[2][2] |=> q.pin[2] == $past(q.sync[2][2])
    ) else $error("vbus level status not updated");

    a_id_sync: assert property (
        q.sync[1][1] == q.sync[2][1] |=> q.pin[1] == $past(q.sync[2][1])
    ) else $error("id status not updated");

    a_valid_sync: assert property (
        q.sync[1][0] == q.sync[2][0] |=> q.pin[0] == $past(q.sync[2][0])
    ) else $error("vbus valid status not updated");

    a_otg_controls: assert property (
        wr && idx == `UFO_IDX_OTG |=> {vbus_pullup_en, rx_pwrdn, chg_pump_en, vbus_dischg_en,
            dp_pu_en, dm_pu_en, dp_pd_en, dm_pd_en} == $past(pwdata[`UFO_OTG_HI:`UFO_OTG_LO])
    ) else $error("otg_port_control_status outputs differ from register write");

endmodule
`default_nettype wire

// >>> rtl/ufo_regs.svh
`ifndef UFO_REGS_SVH
`define UFO_REGS_SVH
// register indices; byte address is four times the index
`define UFO_IDX_FRAME1 16'hc092
`define UFO_IDX_COUNT1 16'hc094
`define UFO_IDX_OTG 16'hc098
`define UFO_IDX_FRAME2 16'hc0b2
`define UFO_IDX_COUNT2 16'hc0b4
`define UFO_IDX_IEN1 16'hc0c0
`define UFO_IDX_STAT1 16'hc0c1
`define UFO_IDX_IEN2 16'hc0c2
`define UFO_IDX_STAT2 16'hc0c3
// reset values
`define UFO_CNT_RST 14'h2ee0
// field positions
`define UFO_CNT_HI 13
`define UFO_OTG_HI 13
`define UFO_OTG_LO 6
`define UFO_STAT_TOF 0
`define UFO_STAT_SOF 1
`define UFO_IEN_TOF 0
// timing: bus clock and down-counter time base, in MHz
`define UFO_CLK_MHZ 6'd20
`define UFO_TB_MHZ 6'd12
`endif

// >>> rtl/ufo_pkg.sv
package ufo_pkg;

    // whole state of the block
    typedef struct packed {
        logic [1:0][13:0] reload;
        logic [1:0][13:0] cnt;
        logic [1:0][2:0] occ;
        logic [1:0][10:0] frame;
        logic [1:0] ien;
        logic [1:0] tof;
        logic [1:0] sofr;
        logic [7:0] otg;
        logic [2:0][2:0] sync;
        logic [2:0] pin;
        logic [4:0] acc;
        logic tick;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ufo_state_t;

endpackage

// >>> tb/ufo_usb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// usb host model: sof and eop pulses
// ****
module ufo_usb_host (
    input wire logic pclk,
    output logic [1:0] sof_rx,
    output logic [1:0] eop_rx,
    output logic [1:0][10:0] sof_frame
);
    // idle: no pulses, frame lines hold no valid number
    initial begin
        sof_rx = 2'h0;
        eop_rx = 2'h0;
        sof_frame = {11'h2aa, 11'h555};
    end
    // one-cycle sof with frame, or eop, on device d
    task automatic send(input int d, input logic eop, input logic [10:0] f);
        @(posedge pclk);
        if (eop) begin
            eop_rx[d] <= 1'h1;
        end else begin
            sof_rx[d] <= 1'h1;
            sof_frame[d] <= f;
        end
        @(posedge pclk);
        sof_rx <= 2'h0;
        eop_rx <= 2'h0;
        sof_frame[d] <= ~f; // stale number not kept on the lines
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_ufo_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufo_regs.svh"
module tb_ufo_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic vbus_ttl, otg_id, vbus_valid;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] sof_rx, eop_rx, full_speed;
    logic [1:0][10:0] sof_frame;
    logic [7:0] pulls;
    int n_fail, checks, i;
    // ****
    // design and far side
    // ****
    ufo_top #(.ADDR_W(18)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sof_rx, .eop_rx, .sof_frame, .full_speed,
        .vbus_ttl, .otg_id, .vbus_valid, .vbus_pullup_en(pulls[7]), .rx_pwrdn(pulls[6]),
        .chg_pump_en(pulls[5]), .vbus_dischg_en(pulls[4]), .dp_pu_en(pulls[3]),
        .dm_pu_en(pulls[2]), .dp_pd_en(pulls[1]), .dm_pd_en(pulls[0]));
    ufo_usb_host host_u (.pclk, .sof_rx, .eop_rx, .sof_frame);
    // 20 mhz clock
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        for (k = 0; k < 10; k++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k == 10) begin
            chk("pready", 32'h0, 32'h1);
            final_report();
        end
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {presetn, psel, penable, pwrite, vbus_ttl, otg_id, vbus_valid} = 7'h0;
        paddr = 18'h0;
        pwdata = 32'h0;
        full_speed = 2'h1;
        n_fail = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `UFO_IDX_COUNT1, 32'h0);
        chk("count1 reset", 32'(rd <= 32'h2ee0 && rd >= 32'h2ed8), 32'h1);
        chk("mapped no error", {31'h0, err}, 32'h0);
        apb(1'h0, `UFO_IDX_COUNT2, 32'h0);
        chk("count2 reset", 32'(rd <= 32'h2ee0 && rd >= 32'h2ed8), 32'h1);
        apb(1'h0, `UFO_IDX_FRAME2, 32'h0);
        chk("frame2 reset", rd, 32'h0);
        apb(1'h0, 16'h0000, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        // each pull control bit alone drives only its own output
        for (i = 0; i < 8; i++) begin
            apb(1'h1, `UFO_IDX_OTG, 32'h40 << i);
            @(negedge pclk);
            chk("pull outputs", {24'h0, pulls}, 32'h1 << i);
        end
        // pin status read after the vbus settle time
        apb(1'h1, `UFO_IDX_OTG, 32'h2800);
        for (i = 0; i < 2; i++) begin
            {vbus_ttl, otg_id, vbus_valid} <= (i == 0) ? 3'h5 : 3'h2;
            repeat (200) @(posedge pclk);
            apb(1'h0, `UFO_IDX_OTG, 32'h0);
            chk("otg status", rd, (i == 0) ? 32'h2805 : 32'h2802);
        end
        // frame kept at full speed only
        host_u.send(0, 1'h0, 11'h5a5);
        host_u.send(1, 1'h0, 11'h3c3);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("frame1", rd, 32'h5a5);
        apb(1'h0, `UFO_IDX_FRAME2, 32'h0);
        chk("frame2 low speed", rd, 32'h0);
        // short interval on both devices: repeated timeouts saturate, frame kept
        apb(1'h1, `UFO_IDX_IEN1, 32'h1);
        apb(1'h1, `UFO_IDX_IEN2, 32'h1);
        apb(1'h1, `UFO_IDX_COUNT1, 32'h2);
        apb(1'h1, `UFO_IDX_COUNT2, 32'h2);
        // clears land at every phase of the expiries, so some meet a set
        for (i = 0; i < 20; i++) begin
            apb(1'h1, `UFO_IDX_STAT1, 32'h1);
        end
        repeat (100) @(posedge pclk);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("frame timeouts", rd, 32'hf5a5);
        apb(1'h0, `UFO_IDX_FRAME2, 32'h0);
        chk("frame2 timeouts", rd, 32'hf000);
        // enable off: eop leaves the occurrence count alone
        apb(1'h1, `UFO_IDX_IEN1, 32'h0);
        apb(1'h1, `UFO_IDX_COUNT1, 32'd1000);
        host_u.send(0, 1'h1, 11'h0);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("occ hold", rd, 32'hf5a5);
        apb(1'h1, `UFO_IDX_IEN1, 32'h1);
        host_u.send(0, 1'h0, 11'h011);
        repeat (200) @(posedge pclk);
        apb(1'h0, `UFO_IDX_COUNT1, 32'h0);
        chk("count rate", 32'(rd >= 32'd870 && rd <= 32'd884), 32'h1);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("occ clear", rd, 32'h8011);
        // write one clears the flag, zero keeps it
        apb(1'h1, `UFO_IDX_STAT1, 32'h0);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("flag kept", rd, 32'h8011);
        apb(1'h0, `UFO_IDX_STAT1, 32'h0);
        chk("status both set", rd, 32'h3);
        apb(1'h1, `UFO_IDX_STAT1, 32'h1);
        apb(1'h0, `UFO_IDX_FRAME1, 32'h0);
        chk("flag cleared", rd, 32'h0011);
        apb(1'h0, `UFO_IDX_STAT1, 32'h0);
        chk("status seen kept", rd, 32'h2);
        // reset in mid-run brings back the reset values
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `UFO_IDX_COUNT1, 32'h0);
        chk("count1 after reset", rd, 32'h2ee0);
        apb(1'h0, `UFO_IDX_FRAME2, 32'h0);
        chk("frame2 after reset", rd, 32'h0);
        chk("pulls after reset", {24'h0, pulls}, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
